//--- afd_alu_flag_datapath.sv
// alu and flag datapath: operand fetch, execute, status, pointers, product
`timescale 1ns/10ps
// Notes on behaviour
// - carry flag lives in status bit 0.
// - nibble carry flag lives in status bit 1.
// - zero flag lives in status bit 2.
// - brown-out bit 3 and watchdog bit 4 untouched by any operation.
// - bank select bits sit in status bits 7 to 5.
// - writes to 0x09 load the program counter; status sits at 0x0B.
// - indirect address is the pointer at 0x04 (high) and 0x05 (low).
// - data pointer at 0x0C/0x0D is a base for offset addressing.
// - stack pointer at 0x06/0x07 is a base for offset addressing.
// - operand is direct, indirect or pointer plus offset, or an immediate byte.
// - and, or, xor, not into accumulator or file; only zero flag changes.
// - add accumulator and operand; carry, nibble carry, zero updated.
// - add with carry sums carry, accumulator and operand; three flags updated.
// - compare is operand minus accumulator; flags updated, nothing written.
// - skip when operand equals accumulator; flags kept.
// - skip when operand differs from accumulator; flags kept.
// - watchdog clear resets counter and prescaler; flags kept.
// - increment, decrement, clear into chosen destination; only zero flag.
// - inc/dec then skip if result zero; status untouched.
// - inc/dec then skip if result nonzero; status untouched.
// - signed multiply: high byte to product register, low byte to accumulator.
// - unsigned multiply likewise; flags untouched.
// - product high byte reads at 0x000F.
module afd_alu_flag_datapath
    import afd_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // command from the decoder
    input wire logic cmd_valid_in,
    input wire afd_cmd_type cmd_in,
    output logic cmd_ready_out,
    // completion to the sequencer
    output logic done_out,
    output logic skip_out,
    // data memory, synchronous read with one cycle latency
    output afd_mem_type mem_out,
    input wire logic [7:0] mem_rdata_in,
    // program counter window
    input wire logic [7:0] pc_low_in,
    output logic pc_write_out,
    output logic [7:0] pc_wdata_out,
    // watchdog and reset cause
    output logic watchdog_clear_out,
    input wire logic brownout_evt_in,
    input wire logic watchdog_timeout_evt_in,
    // visible state
    output logic [7:0] status_out,
    output logic [7:0] acc_out,
    output logic [7:0] product_high_out
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    afd_state_type state_q;
    afd_state_type state_d;
    afd_cmd_type cmd_q;
    logic [15:0] ea_q;
    logic [7:0] w_q;
    logic [7:0] w_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] prodh_q;
    logic [7:0] res_q;
    logic skip_q;
    logic mem_wr_q;
    logic pc_wr_q;

    logic [15:0] ip_ptr;
    logic [15:0] dp_ptr;
    logic [15:0] sp_ptr;

    // --------------------------------------------------------------
    // address formation
    // --------------------------------------------------------------
    wire [15:0] ea_direct = {8'h00, cmd_in.addr8};
    wire [15:0] ea_dp = dp_ptr + {8'h00, cmd_in.ofs8};
    wire [15:0] ea_sp = sp_ptr + {8'h00, cmd_in.ofs8};
    wire [15:0] ea_d = (cmd_in.mode == MODE_INDIRECT) ? ip_ptr :
                       (cmd_in.mode == MODE_DP_OFS) ? ea_dp :
                       (cmd_in.mode == MODE_SP_OFS) ? ea_sp : ea_direct;

    wire hit_ip_hi = (ea_q == ADDR_IP_HI);
    wire hit_ip_lo = (ea_q == ADDR_IP_LO);
    wire hit_sp_hi = (ea_q == ADDR_SP_HI);
    wire hit_sp_lo = (ea_q == ADDR_SP_LO);
    wire hit_pc_win = (ea_q == ADDR_PC_WIN);
    wire hit_acc = (ea_q == ADDR_ACC);
    wire hit_stat = (ea_q == ADDR_STATUS);
    wire hit_dp_hi = (ea_q == ADDR_DP_HI);
    wire hit_dp_lo = (ea_q == ADDR_DP_LO);
    wire hit_prodh = (ea_q == ADDR_PRODH);
    wire sreg_hit = hit_ip_hi | hit_ip_lo | hit_sp_hi | hit_sp_lo | hit_pc_win | hit_acc
                    | hit_stat | hit_dp_hi | hit_dp_lo | hit_prodh;

    // special registers shadow memory; everything else goes to the port
    wire [7:0] sreg_rd = hit_ip_hi ? ip_ptr[15:8] : hit_ip_lo ? ip_ptr[7:0] :
                         hit_sp_hi ? sp_ptr[15:8] : hit_sp_lo ? sp_ptr[7:0] :
                         hit_pc_win ? pc_low_in : hit_acc ? w_q : hit_stat ? status_q :
                         hit_dp_hi ? dp_ptr[15:8] : hit_dp_lo ? dp_ptr[7:0] :
                         prodh_q;
    wire [7:0] opnd = cmd_q.use_imm ? cmd_q.immediate_byte :
                      sreg_hit ? sreg_rd : mem_rdata_in;

    // --------------------------------------------------------------
    // operation decode
    // --------------------------------------------------------------
    wire in_exec = (state_q == ST_EXEC);
    wire afd_op_type op = cmd_q.op;
    wire is_logic = (op == OP_AND) | (op == OP_OR) | (op == OP_XOR) | (op == OP_NOT);
    wire is_arith = (op == OP_ADD) | (op == OP_ADDC) | (op == OP_CMP);
    wire is_plain = (op == OP_INC) | (op == OP_DEC) | (op == OP_CLR);
    wire is_skipz = (op == OP_INCSZ) | (op == OP_DECSZ);
    wire is_skipnz = (op == OP_INCSNZ) | (op == OP_DECSNZ);
    wire is_incr = (op == OP_INC) | (op == OP_INCSZ) | (op == OP_INCSNZ);
    wire is_decr = (op == OP_DEC) | (op == OP_DECSZ) | (op == OP_DECSNZ);
    wire is_mul = (op == OP_MULS) | (op == OP_MULU);
    wire z_upd = is_logic | is_arith | is_plain;
    wire cdc_upd = is_arith;
    wire writes_dest = is_logic | (op == OP_ADD) | (op == OP_ADDC) | is_plain
                       | is_skipz | is_skipnz;
    // immediate forms only ever target the accumulator
    wire file_dst = in_exec & writes_dest & cmd_q.to_file & ~cmd_q.use_imm;
    wire acc_dst = in_exec & ((writes_dest & ~file_dst) | is_mul);

    // --------------------------------------------------------------
    // arithmetic
    // --------------------------------------------------------------
    logic [7:0] add_sum;
    logic add_c;
    logic add_nc;
    // compare runs operand + ~acc + 1, so carry means no borrow
    wire [7:0] add_b = (op == OP_CMP) ? ~w_q : w_q;
    wire add_cin = (op == OP_CMP) | ((op == OP_ADDC) & status_q[STAT_C]);

    afd_nibble_adder u_adder (
        .a_in(opnd),
        .b_in(add_b),
        .cin_in(add_cin),
        .sum_out(add_sum),
        .carry_out(add_c),
        .nibble_carry_out(add_nc)
    );

    wire signed [15:0] prod_s = $signed(w_q) * $signed(opnd);
    wire [15:0] prod_u = w_q * opnd;
    wire [15:0] prod = (op == OP_MULS) ? prod_s : prod_u;

    logic [7:0] res;
    always_comb begin
        unique case (op)
            OP_AND: res = opnd & w_q;
            OP_OR: res = opnd | w_q;
            OP_XOR: res = opnd ^ w_q;
            OP_NOT: res = ~opnd;
            OP_ADD, OP_ADDC, OP_CMP: res = add_sum;
            OP_CLR: res = BYTE_RST;
            OP_INC, OP_INCSZ, OP_INCSNZ: res = opnd + 8'h01;
            OP_DEC, OP_DECSZ, OP_DECSNZ: res = opnd - 8'h01;
            OP_MULS, OP_MULU: res = prod[7:0];
            default: res = opnd;
        endcase
    end

    wire skip_d = ((op == OP_CSE) & (opnd == w_q))
                  | ((op == OP_CSNE) & (opnd != w_q))
                  | (is_skipz & (res == 8'h00))
                  | (is_skipnz & (res != 8'h00));

    // --------------------------------------------------------------
    // status and accumulator next values
    // --------------------------------------------------------------
    wire stat_wr = file_dst & hit_stat;
    // a file write to status may change bank and flag bits only
    wire [7:0] stat_base = stat_wr ? {res[STAT_BANK_MSB:STAT_BANK_LSB],
                                      status_q[STAT_WDOG:STAT_BROWN], res[STAT_Z:STAT_C]}
                                   : status_q;
    assign status_d[STAT_C] = (in_exec & cdc_upd) ? add_c : stat_base[STAT_C];
    assign status_d[STAT_NC] = (in_exec & cdc_upd) ? add_nc : stat_base[STAT_NC];
    assign status_d[STAT_Z] = (in_exec & z_upd) ? (res == 8'h00) : stat_base[STAT_Z];
    assign status_d[STAT_BROWN] = status_q[STAT_BROWN] | brownout_evt_in;
    assign status_d[STAT_WDOG] = status_q[STAT_WDOG] | watchdog_timeout_evt_in;
    assign status_d[STAT_BANK_MSB:STAT_BANK_LSB] = stat_base[STAT_BANK_MSB:STAT_BANK_LSB];

    assign w_d = acc_dst ? res : (file_dst & hit_acc) ? res : w_q;

    // --------------------------------------------------------------
    // pointers
    // --------------------------------------------------------------
    afd_ptr_pair u_ip (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .wr_hi_in(file_dst & hit_ip_hi),
        .wr_lo_in(file_dst & hit_ip_lo),
        .wdata_in(res),
        .ptr_out(ip_ptr)
    );

    afd_ptr_pair u_dp (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .wr_hi_in(file_dst & hit_dp_hi),
        .wr_lo_in(file_dst & hit_dp_lo),
        .wdata_in(res),
        .ptr_out(dp_ptr)
    );

    afd_ptr_pair u_sp (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .wr_hi_in(file_dst & hit_sp_hi),
        .wr_lo_in(file_dst & hit_sp_lo),
        .wdata_in(res),
        .ptr_out(sp_ptr)
    );

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_comb begin
        unique case (state_q)
            ST_IDLE: state_d = cmd_valid_in ? ST_FETCH : ST_IDLE;
            ST_FETCH: state_d = ST_EXEC;
            ST_EXEC: state_d = ST_WB;
            ST_WB: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            ea_q <= PTR_RST;
        end else begin
            state_q <= state_d;
            if (cmd_ready_out && cmd_valid_in) begin
                cmd_q <= cmd_in;
                ea_q <= ea_d;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            w_q <= BYTE_RST;
            status_q <= STATUS_RST;
            prodh_q <= BYTE_RST;
        end else begin
            w_q <= w_d;
            status_q <= status_d;
            if (in_exec && is_mul) begin
                prodh_q <= prod[15:8];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            res_q <= BYTE_RST;
            skip_q <= 1'b0;
            mem_wr_q <= 1'b0;
            pc_wr_q <= 1'b0;
        end else if (in_exec) begin
            res_q <= res;
            skip_q <= skip_d;
            mem_wr_q <= file_dst & ~sreg_hit;
            pc_wr_q <= file_dst & hit_pc_win;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    wire in_wb = (state_q == ST_WB);
    assign cmd_ready_out = (state_q == ST_IDLE);
    assign done_out = in_wb;
    assign skip_out = skip_q;
    // fetch skips the port when the operand is immediate or a special register
    assign mem_out.addr = ea_q;
    assign mem_out.wdata = res_q;
    assign mem_out.we = in_wb & mem_wr_q;
    assign mem_out.re = (state_q == ST_FETCH) & ~cmd_q.use_imm & ~sreg_hit;
    assign pc_write_out = in_wb & pc_wr_q;
    assign pc_wdata_out = res_q;
    assign watchdog_clear_out = in_wb & (op == OP_CWDT);
    assign status_out = status_q;
    assign acc_out = w_q;
    assign product_high_out = prodh_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    wire [8:0] chk_add = {1'b0, opnd} + {1'b0, w_q};
    sequence s_take;
        cmd_valid_in && cmd_ready_out;
    endsequence
    sequence s_walk;
        !cmd_ready_out [*3] ##0 done_out ##1 cmd_ready_out;
    endsequence

    a_cmd_walk_len: assert property (s_take |=> s_walk)
        else $error("command did not complete in four cycles");
    a_cause_bits_held: assert property (in_exec && !brownout_evt_in
        && !watchdog_timeout_evt_in |=> $stable(status_q[STAT_WDOG:STAT_BROWN]))
        else $error("operation altered brown-out or watchdog bit");
    a_add_carry_flag: assert property (in_exec && op == OP_ADD
        |=> status_q[STAT_C] == $past(chk_add[8]))
        else $error("add carry flag wrong");
    a_zero_flag_set: assert property (in_exec && z_upd
        |=> status_q[STAT_Z] == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    a_cmp_no_write: assert property (in_exec && op == OP_CMP
        |=> $stable(w_q) ##0 !mem_out.we ##0 !pc_write_out)
        else $error("compare wrote a result");
    a_cse_skip_eq: assert property (in_exec && op == OP_CSE
        |=> done_out && skip_out == ($past(opnd) == $past(w_q)) && $stable(status_q[2:0]))
        else $error("equal skip wrong");
    a_csne_skip_ne: assert property (in_exec && op == OP_CSNE
        |=> skip_out == ($past(opnd) != $past(w_q)))
        else $error("not-equal skip wrong");
    a_skipz_status: assert property (in_exec && is_skipz && !cmd_q.to_file
        |=> skip_out == (w_q == 8'h00) && $stable(status_q[2:0]))
        else $error("skip on zero wrong");
    a_mulu_product: assert property (in_exec && op == OP_MULU
        |=> {prodh_q, w_q} == $past(w_q) * $past(opnd))
        else $error("unsigned product wrong");
    a_muls_product: assert property (in_exec && op == OP_MULS
        |=> $signed({prodh_q, w_q}) == $signed($past(w_q)) * $signed($past(opnd)))
        else $error("signed product wrong");
    a_cwdt_pulse: assert property (in_exec && op == OP_CWDT
        |=> watchdog_clear_out ##1 !watchdog_clear_out)
        else $error("watchdog clear not a single pulse");

endmodule : afd_alu_flag_datapath

//--- afd_nibble_adder.sv
// eight-bit adder with carry out of bit 7 and of bit 3
`timescale 1ns/10ps
module afd_nibble_adder (
    // operands
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic cin_in,
    // result
    output logic [7:0] sum_out,
    output logic carry_out,
    output logic nibble_carry_out
);
    logic [4:0] low_sum;
    logic [4:0] high_sum;

    // split so the nibble carry is a real adder carry, not a guess
    assign low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
    assign high_sum = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, low_sum[4]};
    assign sum_out = {high_sum[3:0], low_sum[3:0]};
    assign carry_out = high_sum[4];
    assign nibble_carry_out = low_sum[4];

endmodule : afd_nibble_adder

//--- afd_pkg.sv
// shared constants, enumerations and carriers of the alu and flag datapath
package afd_pkg;

    // --------------------------------------------------------------
    // direct addresses of the special registers
    // --------------------------------------------------------------
    localparam logic [15:0] ADDR_IP_HI = 16'h0004;
    localparam logic [15:0] ADDR_IP_LO = 16'h0005;
    localparam logic [15:0] ADDR_SP_HI = 16'h0006;
    localparam logic [15:0] ADDR_SP_LO = 16'h0007;
    localparam logic [15:0] ADDR_PC_WIN = 16'h0009;
    localparam logic [15:0] ADDR_ACC = 16'h000A;
    localparam logic [15:0] ADDR_STATUS = 16'h000B;
    localparam logic [15:0] ADDR_DP_HI = 16'h000C;
    localparam logic [15:0] ADDR_DP_LO = 16'h000D;
    localparam logic [15:0] ADDR_PRODH = 16'h000F;

    // --------------------------------------------------------------
    // status field positions and reset values
    // --------------------------------------------------------------
    localparam int STAT_C = 0;
    localparam int STAT_NC = 1;
    localparam int STAT_Z = 2;
    localparam int STAT_BROWN = 3;
    localparam int STAT_WDOG = 4;
    localparam int STAT_BANK_LSB = 5;
    localparam int STAT_BANK_MSB = 7;
    localparam logic [7:0] STATUS_RST = 8'hE0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;

    // --------------------------------------------------------------
    // operations, addressing modes, sequencer states
    // --------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_AND, OP_OR, OP_XOR, OP_NOT, OP_ADD, OP_ADDC, OP_CLR, OP_CMP,
        OP_CSE, OP_CSNE, OP_CWDT, OP_INC, OP_DEC, OP_INCSZ, OP_INCSNZ,
        OP_DECSZ, OP_DECSNZ, OP_MULS, OP_MULU
    } afd_op_type;

    typedef enum logic [1:0] {MODE_DIRECT, MODE_INDIRECT, MODE_DP_OFS, MODE_SP_OFS} afd_mode_type;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_WB} afd_state_type;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        afd_op_type op;
        afd_mode_type mode;
        logic to_file;
        logic use_imm;
        logic [7:0] addr8;
        logic [7:0] ofs8;
        logic [7:0] immediate_byte;
    } afd_cmd_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } afd_mem_type;

endpackage : afd_pkg

//--- afd_ptr_pair.sv
// one sixteen-bit pointer held as two byte-writable halves
`timescale 1ns/10ps
module afd_ptr_pair
    import afd_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // byte writes
    input wire logic wr_hi_in,
    input wire logic wr_lo_in,
    input wire logic [7:0] wdata_in,
    // pointer value
    output logic [15:0] ptr_out
);
    logic [15:0] ptr_q;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ptr_q <= PTR_RST;
        end else begin
            if (wr_hi_in) begin
                ptr_q[15:8] <= wdata_in;
            end
            if (wr_lo_in) begin
                ptr_q[7:0] <= wdata_in;
            end
        end
    end

    assign ptr_out = ptr_q;

endmodule : afd_ptr_pair

//--- afd_ram_model.sv
// synchronous data memory model on the far side of the datapath memory port
`timescale 1ns/10ps
module afd_ram_model
    import afd_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // memory port of the datapath
    input wire afd_mem_type mem_in,
    output logic [7:0] rdata_out
);
    // ----------------------------------------
    // storage and read pipe
    // ----------------------------------------
    logic [7:0] mem [logic [15:0]];
    initial rdata_out = 8'hA5;
    // data only follows a read strobe; otherwise the line toggles so stale bytes never match
    always @(posedge mclk_in) begin
        if (mem_in.re) begin
            rdata_out <= mem.exists(mem_in.addr) ? mem[mem_in.addr] : 8'h00;
        end else begin
            rdata_out <= ~rdata_out;
        end
        if (mem_in.we) begin
            mem[mem_in.addr] = mem_in.wdata;
        end
    end
endmodule : afd_ram_model

//--- tb_top.sv
// self-checking bench of the alu and flag datapath
`timescale 1ns/10ps
module tb_top;
    import afd_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    afd_cmd_type cmd_in = '0;
    logic brown_evt = 1'b0;
    logic wdog_evt = 1'b0;
    logic cmd_ready, done_out, skip_out, pc_write_out, wdg_clear, skp, pcw, wdc;
    afd_mem_type mem_out;
    logic [7:0] rdata, pc_wdata_out, status_out, acc_out, product_high_out, pcd;
    int err_total = 0;
    int checks_done = 0;
    initial forever #25 mclk_in = ~mclk_in;
    afd_alu_flag_datapath afd_alu_flag_datapath_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready),
        .done_out(done_out), .skip_out(skip_out), .mem_out(mem_out), .mem_rdata_in(rdata),
        .pc_low_in(8'h30), .pc_write_out(pc_write_out), .pc_wdata_out(pc_wdata_out),
        .watchdog_clear_out(wdg_clear), .brownout_evt_in(brown_evt),
        .watchdog_timeout_evt_in(wdog_evt),
        .status_out(status_out), .acc_out(acc_out), .product_high_out(product_high_out));
    afd_ram_model afd_ram_model_i (.mclk_in(mclk_in), .mem_in(mem_out), .rdata_out(rdata));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test();
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // one command; completion is expected on the third falling edge after the take edge
    task go(input afd_op_type o, input afd_mode_type m, input logic f, input logic i,
            input logic [7:0] a, input logic [7:0] s, input logic [7:0] v);
        int n;
        cmd_in = '{o, m, f, i, a, s, v};
        cmd_valid_in = 1'b1;
        @(posedge mclk_in);
        @(negedge mclk_in);
        cmd_valid_in = 1'b0;
        n = 1;
        while (done_out !== 1'b1 && n < 8) begin
            @(negedge mclk_in);
            n++;
        end
        skp = skip_out;
        pcw = pc_write_out;
        pcd = pc_wdata_out;
        wdc = wdg_clear;
        chk(n[7:0], 8'h03);
        chk({cmd_ready, done_out}, 2'h1);
        if (n == 8) end_of_test();
        @(negedge mclk_in);
        chk(cmd_ready, 1'h1);
    endtask : go
    task imm(input afd_op_type o, input logic [7:0] v);
        go(o, MODE_DIRECT, 1'b0, 1'b1, 8'h00, 8'h00, v);
    endtask : imm
    task fil(input afd_op_type o, input logic [7:0] a, input logic f);
        go(o, MODE_DIRECT, f, 1'b0, a, 8'h00, 8'h00);
    endtask : fil
    task set_acc(input logic [7:0] v);
        fil(OP_CLR, 8'h00, 1'b0);
        imm(OP_OR, v);
    endtask : set_acc
    task set_reg(input logic [7:0] a, input logic [7:0] v);
        set_acc(v);
        fil(OP_CLR, a, 1'b1);
        fil(OP_OR, a, 1'b1);
    endtask : set_reg
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_add();
        afd_ram_model_i.mem[16'h0041] = 8'h70;
        set_acc(8'h8F);
        fil(OP_ADDC, 8'h41, 1'b0);
        chk({status_out, acc_out}, 16'hE0FF);
        imm(OP_ADD, 8'h01);
        chk({status_out, acc_out}, 16'hE700);
        fil(OP_ADDC, 8'h41, 1'b0);
        chk({status_out, acc_out}, 16'hE071);
        imm(OP_ADD, 8'h0F);
        chk({status_out, acc_out}, 16'hE280);
        imm(OP_ADD, 8'h80);
        chk({status_out, acc_out}, 16'hE500);
    endtask : t_add
    task t_logic();
        imm(OP_AND, 8'h0F);
        chk({status_out, acc_out}, 16'hE500);
        imm(OP_OR, 8'h0F);
        chk({status_out, acc_out}, 16'hE10F);
        imm(OP_XOR, 8'h0F);
        chk({status_out, acc_out}, 16'hE500);
        afd_ram_model_i.mem[16'h0040] = 8'h5A;
        fil(OP_NOT, 8'h40, 1'b1);
        chk({afd_ram_model_i.mem[16'h0040], status_out, acc_out}, 24'hA5E100);
    endtask : t_logic
    task t_cmp();
        set_acc(8'h05);
        imm(OP_CMP, 8'h03);
        chk({status_out, acc_out}, 16'hE005);
        imm(OP_CMP, 8'h05);
        chk({status_out, acc_out}, 16'hE705);
        afd_ram_model_i.mem[16'h0044] = 8'h14;
        fil(OP_CMP, 8'h44, 1'b1);
        chk({status_out, acc_out, afd_ram_model_i.mem[16'h0044]}, 24'hE10514);
        imm(OP_CSE, 8'h05);
        chk({skp, status_out}, 9'h1E1);
        fil(OP_CSE, 8'h44, 1'b0);
        chk({skp, status_out}, 9'h0E1);
        imm(OP_CSNE, 8'h05);
        chk({skp, status_out}, 9'h0E1);
        imm(OP_CSNE, 8'h06);
        chk({skp, status_out, acc_out}, 17'h1E105);
    endtask : t_cmp
    task t_incdec();
        afd_ram_model_i.mem[16'h0042] = 8'hFF;
        fil(OP_INCSZ, 8'h42, 1'b1);
        chk({skp, status_out, afd_ram_model_i.mem[16'h0042]}, 17'h1E100);
        fil(OP_DECSNZ, 8'h42, 1'b1);
        chk({skp, status_out, afd_ram_model_i.mem[16'h0042]}, 17'h1E1FF);
        fil(OP_INCSNZ, 8'h42, 1'b0);
        chk({skp, status_out, acc_out}, 17'h0E100);
        fil(OP_DECSZ, 8'h42, 1'b0);
        chk({skp, status_out, acc_out}, 17'h0E1FE);
        fil(OP_INC, 8'h42, 1'b1);
        chk({status_out, afd_ram_model_i.mem[16'h0042]}, 16'hE500);
        fil(OP_DEC, 8'h42, 1'b1);
        chk({status_out, afd_ram_model_i.mem[16'h0042]}, 16'hE1FF);
        fil(OP_CLR, 8'h42, 1'b1);
        chk({status_out, afd_ram_model_i.mem[16'h0042]}, 16'hE500);
    endtask : t_incdec
    task t_mul();
        set_acc(8'hFE);
        imm(OP_MULS, 8'h03);
        chk({status_out, product_high_out, acc_out}, 24'hE1FFFA);
        set_acc(8'hFE);
        imm(OP_MULU, 8'h03);
        chk({status_out, product_high_out, acc_out}, 24'hE102FA);
        afd_ram_model_i.mem[16'h0045] = 8'h80;
        set_acc(8'hFF);
        fil(OP_MULS, 8'h45, 1'b0);
        chk({product_high_out, acc_out}, 16'h0080);
        set_acc(8'hFF);
        fil(OP_MULU, 8'h45, 1'b0);
        set_acc(8'h00);
        fil(OP_OR, 8'h0F, 1'b0);
        chk(acc_out, 8'h7F);
    endtask : t_mul
    task t_addr();
        set_reg(8'h04, 8'h01);
        set_reg(8'h05, 8'h23);
        set_reg(8'h0C, 8'h02);
        set_reg(8'h0D, 8'h00);
        set_reg(8'h06, 8'h03);
        set_reg(8'h07, 8'h00);
        afd_ram_model_i.mem[16'h0123] = 8'h3C;
        afd_ram_model_i.mem[16'h0210] = 8'h41;
        afd_ram_model_i.mem[16'h03FF] = 8'h7E;
        set_acc(8'h00);
        go(OP_OR, MODE_INDIRECT, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        chk(acc_out, 8'h3C);
        go(OP_XOR, MODE_DP_OFS, 1'b0, 1'b0, 8'h00, 8'h10, 8'h00);
        chk(acc_out, 8'h7D);
        go(OP_ADD, MODE_SP_OFS, 1'b1, 1'b0, 8'h00, 8'hFF, 8'h00);
        chk(afd_ram_model_i.mem[16'h03FF], 8'hFB);
    endtask : t_addr
    task t_special();
        set_acc(8'h05);
        fil(OP_OR, 8'h09, 1'b1);
        chk({pcw, pcd}, 9'h135);
        set_acc(8'h18);
        fil(OP_OR, 8'h0B, 1'b0);
        chk({status_out, acc_out}, 16'hE2FA);
        set_acc(8'h1A);
        fil(OP_OR, 8'h0B, 1'b1);
        chk(status_out, 8'hE2);
        go(OP_CWDT, MODE_DIRECT, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        chk({wdc, status_out}, 9'h1E2);
        brown_evt = 1'b1;
        @(negedge mclk_in);
        brown_evt = 1'b0;
        wdog_evt = 1'b1;
        @(negedge mclk_in);
        wdog_evt = 1'b0;
        imm(OP_ADD, 8'h00);
        chk({status_out, acc_out}, 16'hF81A);
    endtask : t_special
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(negedge mclk_in);
        nrst_in = 1'b1;
        chk({status_out, acc_out, product_high_out}, 24'hE00000);
        t_add();
        t_logic();
        t_cmp();
        t_incdec();
        t_mul();
        t_addr();
        t_special();
        end_of_test();
    end
endmodule : tb_top
